// ### verilog/cbt_defines.svh
// Overview of operation
// - Each time quantum the bus is compared with the last sample point level.
// - Only recessive-to-dominant edges synchronise; dominant-to-recessive never do.
// - Phase error is zero in the sync quantum, else signed distance to it.
// - The first qualifying edge at frame start causes a hard synchronisation.
// - Hard sync restarts the bit as if the sync quantum just ended.
// - A late edge lengthens the first phase segment by min(error, jump width).
// - An early edge shortens the second phase segment by min(error, jump width).
// - An early edge within the jump width skips the sync quantum of the next bit.
// - At most one synchronisation happens between two sample points.
// - Segment changes last one bit; the next bit uses nominal lengths.
// - The bit timing machine starts each bit with the sync quantum, except after an early edge within the jump width, and ends it after the second phase segment.
// - One sample per bit at the sample point; no majority filter.
// - The bus is sampled while transmitting too.
// - The sync segment always lasts exactly one time quantum.
// - One time quantum is prescaler value times the clock period.
// - Prescaler, jump width and segment fields are programmed minus one.
// - The bit timing machine advances exactly once per time quantum.
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH

`define CBT_ADDR_W 8
`define CBT_ADDR_BTIME 8'h00
`define CBT_ADDR_STATUS 8'h04
`define CBT_BTIME_RST 16'h2301
`define CBT_BRP_LSB 0
`define CBT_SJW_LSB 6
`define CBT_TSEG1_LSB 8
`define CBT_TSEG2_LSB 12
`define CBT_BTIME_MASK 16'h7fff
`define CBT_SYNC_TQ 1

`endif

// ### verilog/cbt_pkg.sv
`default_nettype none
package cbt_pkg;

    // Bit timing states, bit seen from sync quantum to end of second phase segment
    typedef enum logic [1:0] {
        CBT_ST_SYNC = 2'b00,
        CBT_ST_TSEG1 = 2'b01,
        CBT_ST_TSEG2 = 2'b10
    } cbt_state_t;

    // Programmed timing, every field except resv one less than its length
    typedef struct packed {
        logic resv;
        logic [2:0] tseg2;
        logic [3:0] tseg1;
        logic [1:0] sjw;
        logic [5:0] brp;
    } cbt_btime_t;

    // Result handed to the bit stream side
    typedef struct packed {
        logic strobe;
        logic bit_val;
    } cbt_sample_t;

endpackage : cbt_pkg
`default_nettype wire

// ### verilog/cbt_in_sync.sv
`timescale 1ns/10ps
`default_nettype none
module cbt_in_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Asynchronous pin and its filtered level
    input wire logic pin,
    output logic level
);
    logic ff1_r;
    logic ff2_r;
    logic ff3_r;
    logic level_r;

    // Three-stage chain; first stage feeds only the second
    always_ff @(posedge clock) begin
        if (rst) begin
            ff1_r <= RST_VAL;
            ff2_r <= RST_VAL;
            ff3_r <= RST_VAL;
        end else begin
            ff1_r <= pin;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end

    // Level accepted once stages two and three agree
    always_ff @(posedge clock) begin
        if (rst) begin
            level_r <= RST_VAL;
        end else if (ff2_r == ff3_r) begin
            level_r <= ff3_r;
        end
    end

    assign level = level_r;

endmodule : cbt_in_sync
`default_nettype wire

// ### verilog/cbt_tq_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module cbt_tq_prescaler #(
    parameter int BRP_W = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Programmed prescaler minus one, and quantum tick
    input wire logic [BRP_W-1:0] brp,
    output logic tq_tick
);
    logic [BRP_W-1:0] cnt_r;

    // Tick every brp+1 clocks
    assign tq_tick = (cnt_r >= brp);

    // Quantum counter
    always_ff @(posedge clock) begin
        if (rst || tq_tick) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    sequence s_tick_gap;
        !tq_tick [*1];
    endsequence

    a_tick_spacing: assert property (@(posedge clock) disable iff (rst)
        (tq_tick && brp != '0) |=> s_tick_gap)
        else $error("quantum ticks too close");

endmodule : cbt_tq_prescaler
`default_nettype wire

// ### verilog/cbt_core.sv
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "cbt_defines.svh"
module cbt_core
    import cbt_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [`CBT_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Bus pins through the transceiver
    input wire logic can_rx,
    output logic can_tx,
    // Bit stream processor
    input wire logic bsp_hard_sync_en,
    input wire logic bsp_resync_en,
    input wire logic bsp_tx_bit,
    output cbt_sample_t bsp_sample
);
    cbt_btime_t btime_r;
    cbt_state_t state_r;
    cbt_state_t state_nxt;
    logic [15:0] rdata_r;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [2:0] ext_r;
    logic [2:0] ext_nxt;
    logic [2:0] shrink_r;
    logic [2:0] shrink_nxt;
    logic synced_r;
    logic prev_r;
    logic sample_bit_r;
    logic strobe_r;
    logic tx_r;
    logic last_hard_r;
    logic [1:0] sync_cnt_r;
    logic rx;
    logic tq_tick;
    logic sp;
    logic bit_start;
    logic edge_ok;
    logic hard_ev;
    logic resync_ev;
    logic [2:0] sjw_f;
    logic [4:0] len1;
    logic [3:0] len2;
    logic [4:0] err;
    logic [2:0] amt;
    logic [3:0] mag;

    // Bus pin into the clock domain
    cbt_in_sync #(
        .RST_VAL(1'b1)
    ) u_rx_sync (
        .clock(clock),
        .rst(rst),
        .pin(can_rx),
        .level(rx)
    );

    // Time quantum generator
    cbt_tq_prescaler #(
        .BRP_W(6)
    ) u_prescaler (
        .clock(clock),
        .rst(rst),
        .brp(btime_r.brp),
        .tq_tick(tq_tick)
    );

    // Functional lengths from minus-one fields
    assign sjw_f = {1'b0, btime_r.sjw} + 3'd1;
    assign len1 = {1'b0, btime_r.tseg1} + 5'd1 + {2'b00, ext_r};
    assign len2 = {1'b0, btime_r.tseg2} + 4'd1 - {1'b0, shrink_r};

    // Falling bus after a recessive sample, once per bit
    assign edge_ok = tq_tick && prev_r && !rx && !synced_r;
    assign hard_ev = edge_ok && bsp_hard_sync_en;
    assign resync_ev = edge_ok && !bsp_hard_sync_en && bsp_resync_en;

    // Phase error magnitudes and the bounded correction
    assign err = cnt_r + 5'd1;
    assign amt = (err < {2'b00, sjw_f}) ? err[2:0] : sjw_f;
    assign mag = len2 - cnt_r[3:0];

    // Next bit timing state, evaluated only on a quantum tick
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ext_nxt = ext_r;
        shrink_nxt = shrink_r;
        sp = 1'b0;
        bit_start = 1'b0;
        if (tq_tick) begin
            unique case (state_r)
                CBT_ST_SYNC: begin
                    state_nxt = CBT_ST_TSEG1;
                    cnt_nxt = 5'd0;
                end
                CBT_ST_TSEG1: begin
                    if (cnt_r + 5'd1 >= len1) begin
                        sp = 1'b1;
                        state_nxt = CBT_ST_TSEG2;
                        cnt_nxt = 5'd0;
                        ext_nxt = 3'd0;
                    end else begin
                        cnt_nxt = cnt_r + 5'd1;
                    end
                end
                CBT_ST_TSEG2: begin
                    if (cnt_r + 5'd1 >= {1'b0, len2}) begin
                        state_nxt = CBT_ST_SYNC;
                        cnt_nxt = 5'd0;
                        shrink_nxt = 3'd0;
                        bit_start = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 5'd1;
                    end
                end
                default: begin
                    state_nxt = CBT_ST_SYNC;
                    cnt_nxt = 5'd0;
                end
            endcase
            if (hard_ev) begin
                // Edge quantum becomes the sync quantum
                sp = 1'b0;
                bit_start = (state_r == CBT_ST_TSEG2);
                state_nxt = CBT_ST_TSEG1;
                cnt_nxt = 5'd0;
                ext_nxt = 3'd0;
                shrink_nxt = 3'd0;
            end else if (resync_ev && state_r == CBT_ST_TSEG1) begin
                // Late edge: stretch the first phase segment
                sp = 1'b0;
                state_nxt = CBT_ST_TSEG1;
                ext_nxt = amt;
                cnt_nxt = cnt_r + 5'd1;
            end else if (resync_ev && state_r == CBT_ST_TSEG2) begin
                if (mag <= {1'b0, sjw_f}) begin
                    // Early edge fully absorbed, sync quantum omitted
                    state_nxt = CBT_ST_TSEG1;
                    cnt_nxt = 5'd0;
                    shrink_nxt = 3'd0;
                    bit_start = 1'b1;
                end else if (cnt_r + 5'd1 >=
                             {1'b0, len2 - {1'b0, sjw_f}}) begin
                    state_nxt = CBT_ST_SYNC;
                    cnt_nxt = 5'd0;
                    shrink_nxt = 3'd0;
                    bit_start = 1'b1;
                end else begin
                    shrink_nxt = shrink_r + sjw_f;
                    cnt_nxt = cnt_r + 5'd1;
                end
            end
        end
    end

    // Bit timing registers
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= CBT_ST_SYNC;
            cnt_r <= 5'd0;
            ext_r <= 3'd0;
            shrink_r <= 3'd0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ext_r <= ext_nxt;
            shrink_r <= shrink_nxt;
        end
    end

    // One synchronisation per sample-point interval
    always_ff @(posedge clock) begin
        if (rst) begin
            synced_r <= 1'b0;
            last_hard_r <= 1'b0;
        end else if (hard_ev || resync_ev) begin
            synced_r <= 1'b1;
            last_hard_r <= hard_ev;
        end else if (sp) begin
            synced_r <= 1'b0;
        end
    end

    // Syncs seen since the last sample point, saturating, for the checks
    always_ff @(posedge clock) begin
        if (rst || sp) begin
            sync_cnt_r <= 2'd0;
        end else if ((hard_ev || resync_ev) && sync_cnt_r != 2'd3) begin
            sync_cnt_r <= sync_cnt_r + 2'd1;
        end
    end

    // Single sample at the sample point, also while sending
    always_ff @(posedge clock) begin
        if (rst) begin
            prev_r <= 1'b1;
            sample_bit_r <= 1'b1;
            strobe_r <= 1'b0;
        end else begin
            strobe_r <= sp;
            if (sp) begin
                prev_r <= rx;
                sample_bit_r <= rx;
            end
        end
    end

    // Transmit bit launched at each bit start, recessive at reset
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_r <= 1'b1;
        end else if (bit_start) begin
            tx_r <= bsp_tx_bit;
        end
    end

    assign can_tx = tx_r;
    assign bsp_sample.strobe = strobe_r;
    assign bsp_sample.bit_val = sample_bit_r;

    // Timing register write
    always_ff @(posedge clock) begin
        if (rst) begin
            btime_r <= `CBT_BTIME_RST;
        end else if (reg_wr && reg_addr == `CBT_ADDR_BTIME) begin
            btime_r <= reg_wdata & `CBT_BTIME_MASK;
        end
    end

    // Read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_r <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `CBT_ADDR_BTIME: rdata_r <= btime_r;
                `CBT_ADDR_STATUS: rdata_r <= {11'h000, state_r,
                    last_hard_r, synced_r, sample_bit_r};
                default: rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_r;

    // Checks
    sequence s_strobe_once;
        bsp_sample.strobe ##1 !bsp_sample.strobe;
    endsequence

    sequence s_hard_restart;
        state_r == CBT_ST_TSEG1 && cnt_r == 5'd0;
    endsequence

    a_rise_no_sync: assert property (@(posedge clock) disable iff (rst)
        (hard_ev || resync_ev) |-> (bsp_sample.bit_val && !rx))
        else $error("sync without falling edge");

    a_one_sync_bit: assert property (@(posedge clock) disable iff (rst)
        (hard_ev || resync_ev) |-> sync_cnt_r == 2'd0)
        else $error("second sync before sample point");

    a_hard_restart: assert property (@(posedge clock) disable iff (rst)
        hard_ev |=> s_hard_restart)
        else $error("hard sync did not restart bit");

    a_strobe_pulse: assert property (@(posedge clock) disable iff (rst)
        $rose(bsp_sample.strobe) |-> s_strobe_once)
        else $error("sample strobe longer than one cycle");

    a_sample_value: assert property (@(posedge clock) disable iff (rst)
        bsp_sample.strobe |-> bsp_sample.bit_val == $past(rx))
        else $error("sampled bit differs from bus");

    a_sync_one_tq: assert property (@(posedge clock) disable iff (rst)
        (state_r == CBT_ST_SYNC && tq_tick)
        |=> state_r == CBT_ST_TSEG1)
        else $error("sync segment not one quantum");

    a_ext_bound: assert property (@(posedge clock) disable iff (rst)
        ext_r <= sjw_f)
        else $error("lengthening exceeds jump width");

    a_ext_restore: assert property (@(posedge clock) disable iff (rst)
        sp |=> ext_r == 3'd0 && state_r == CBT_ST_TSEG2)
        else $error("lengthening kept past sample point");

    a_early_skip: assert property (@(posedge clock) disable iff (rst)
        (resync_ev && state_r == CBT_ST_TSEG2 && mag <= {1'b0, sjw_f})
        |=> state_r == CBT_ST_TSEG1 && cnt_r == 5'd0)
        else $error("early edge did not skip sync segment");

    a_state_on_tick: assert property (@(posedge clock) disable iff (rst)
        !tq_tick |=> $stable(state_r) && $stable(cnt_r))
        else $error("bit timing moved without quantum tick");

    a_late_lengthen: assert property (@(posedge clock) disable iff (rst)
        (resync_ev && state_r == CBT_ST_TSEG1) |=> ext_r == $past(amt))
        else $error("late edge lengthening wrong");

endmodule : cbt_core
`default_nettype wire

// ### dv/cbt_bus_node.sv
`timescale 1ns/10ps
`default_nettype none
module cbt_bus_node (
    // Drive request from the bench, high pulls the bus dominant
    input wire logic dom_req,
    // Block side of the bus
    input wire logic dut_tx,
    output logic can_rx
);
    // Wired-AND bus with pull-up, so any dominant driver wins
    assign can_rx = dut_tx & ~dom_req;
endmodule : cbt_bus_node
`default_nettype wire

// ### dv/cbt_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "cbt_defines.svh"
`define CBT_CHK(what, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("wrong value %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module cbt_core_tb
    import cbt_pkg::*;
;
    logic clock, rst, reg_wr, reg_rd, can_rx, can_tx, prev_strobe;
    logic hs_en, rs_en, tx_bit, node_dom;
    logic [`CBT_ADDR_W-1:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_val;
    cbt_sample_t bsp_sample;
    int mismatches, num_checks, per, d_hard;

    cbt_core DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .can_rx(can_rx), .can_tx(can_tx),
        .bsp_hard_sync_en(hs_en), .bsp_resync_en(rs_en),
        .bsp_tx_bit(tx_bit), .bsp_sample(bsp_sample));
    cbt_bus_node NODE (.dom_req(node_dom), .dut_tx(can_tx), .can_rx(can_rx));

    // Free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Strobe must never stand two cycles in a row, looked at mid-cycle
    always @(negedge clock) begin
        if (!rst) begin
            `CBT_CHK("strobe width", 1'b0, prev_strobe & bsp_sample.strobe)
        end
        prev_strobe <= bsp_sample.strobe;
    end

    // Run summary and verdict, ends the run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    // Counts cycles up to the next sample strobe, bounded
    task automatic wait_strobe(output int n);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (bsp_sample.strobe !== 1'b1 && n < 400);
        if (n >= 400) begin
            mismatches++;
            $display("wrong value strobe expected 1 seen 0");
        end
    endtask : wait_strobe

    // Nominal bit length in clocks from the programmed fields
    function automatic int bit_len(cbt_btime_t b);
        return (int'(b.brp) + 1) * (int'(b.tseg1) + int'(b.tseg2) + 3);
    endfunction : bit_len

    // Falling edge x+1 clocks after a strobe, one dominant bit, release
    task automatic edge_run(input int x, output int d);
        int n;
        wait_strobe(n);
        repeat (x + 1) @(posedge clock);
        node_dom <= 1'b1;
        wait_strobe(d);
        `CBT_CHK("dominant bit", 1'b0, bsp_sample.bit_val)
        @(posedge clock);
        node_dom <= 1'b0;
        wait_strobe(n);
        `CBT_CHK("bit after sync", per, n + 1)
        `CBT_CHK("recessive bit", 1'b1, bsp_sample.bit_val)
    endtask : edge_run

    task automatic t_regs();
        reg_read(`CBT_ADDR_BTIME, rd_val);
        `CBT_CHK("timing reset", 16'h2301, rd_val)
        @(posedge clock);
        #1;
        `CBT_CHK("idle read data", 16'h0000, reg_rdata)
        reg_read(8'h08, rd_val);
        `CBT_CHK("unmapped read", 16'h0000, rd_val)
        reg_write(`CBT_ADDR_BTIME, 16'hffff);
        reg_read(`CBT_ADDR_BTIME, rd_val);
        `CBT_CHK("timing reserved bit", 16'h7fff, rd_val)
        reg_write(`CBT_ADDR_STATUS, 16'h0000);
        reg_read(`CBT_ADDR_STATUS, rd_val);
        `CBT_CHK("status sampled bit", 1'b1, rd_val[0])
        `CBT_CHK("status hard flag", 1'b0, rd_val[2])
    endtask : t_regs

    // Bit spacing for two settings, bus idle recessive
    task automatic t_nominal();
        logic [15:0] cfgs [2];
        int n;
        cfgs[0] = 16'h1202;
        cfgs[1] = 16'h7540;
        foreach (cfgs[i]) begin
            reg_write(`CBT_ADDR_BTIME, cfgs[i]);
            per = bit_len(cbt_btime_t'(cfgs[i]));
            repeat (3) wait_strobe(n);
            `CBT_CHK("bit length", per, n)
            `CBT_CHK("idle bit", 1'b1, bsp_sample.bit_val)
        end
    endtask : t_nominal

    // Hard sync delay must not depend on where the edge falls
    task automatic t_hard();
        int d2;
        @(posedge clock);
        hs_en <= 1'b1;
        edge_run(2, d_hard);
        edge_run(6, d2);
        `CBT_CHK("hard sync delay", d_hard, d2)
        reg_read(`CBT_ADDR_STATUS, rd_val);
        `CBT_CHK("status hard flag", 1'b1, rd_val[2])
        @(posedge clock);
        hs_en <= 1'b0;
    endtask : t_hard

    // Early and late edges against a jump width of two quanta
    task automatic t_resync();
        int errs [6] = '{-3, -1, 0, 1, 2, 4};
        int x, d, m, r, e;
        @(posedge clock);
        rs_en <= 1'b1;
        foreach (errs[i]) begin
            x = per - 1 - d_hard + errs[i];
            m = (errs[i] < 0) ? -errs[i] : errs[i];
            // Residual error left after a jump of at most two quanta
            r = m - ((m < 2) ? m : 2);
            e = (errs[i] < 0) ? d_hard + r : d_hard - r;
            if (x >= 0) begin
                edge_run(x, d);
                `CBT_CHK("resync delay", e, d)
            end
        end
        @(posedge clock);
        rs_en <= 1'b0;
        reg_read(`CBT_ADDR_STATUS, rd_val);
        `CBT_CHK("status resync flag", 1'b0, rd_val[2])
    endtask : t_resync

    // Own dominant bits and a foreign dominant seen while sending
    task automatic t_tx();
        int n;
        @(posedge clock);
        tx_bit <= 1'b0;
        repeat (3) wait_strobe(n);
        `CBT_CHK("sent dominant", 1'b0, can_tx)
        `CBT_CHK("own dominant seen", 1'b0, bsp_sample.bit_val)
        @(posedge clock);
        tx_bit <= 1'b1;
        node_dom <= 1'b1;
        repeat (3) wait_strobe(n);
        `CBT_CHK("sent recessive", 1'b1, can_tx)
        `CBT_CHK("foreign dominant", 1'b0, bsp_sample.bit_val)
        @(posedge clock);
        node_dom <= 1'b0;
    endtask : t_tx

    // Main sequence
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        hs_en = 1'b0;
        rs_en = 1'b0;
        tx_bit = 1'b1;
        node_dom = 1'b0;
        prev_strobe = 1'b0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_nominal();
        t_hard();
        t_resync();
        t_tx();
        print_verdict();
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        mismatches++;
        print_verdict();
    end
endmodule : cbt_core_tb
`default_nettype wire
